// ==== design/dc_offset_servo_control.sv ====
// top: register slave, write sequencer hook and correction engine of the offset servo
`timescale 1ns/1ns
`default_nettype none
module dc_offset_servo_control #(
    parameter longint unsigned UPDATE_PERIOD_CYCLES = dc_servo_pkg::UPDATE_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [dc_servo_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // write sequencer run pulse
    input wire logic seq_run,
    // measurement front end
    output dc_servo_pkg::meas_req_s meas_req,
    input wire dc_servo_pkg::meas_ans_s meas_ans,
    // correction drive
    output dc_servo_pkg::corr_bank_t corr_value,
    output logic [3:0] corr_apply
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [dc_servo_pkg::TIMER_W-1:0] TICK_LAST =
        dc_servo_pkg::TIMER_W'(UPDATE_PERIOD_CYCLES - 64'd1);

    logic wait_ff; // high until a request is answered
    logic [31:0] rdata_ff; // read data, latched a cycle before the answer
    logic master_ff; // global servo enable
    logic [3:0] out_en_ff; // per-output enables
    dc_servo_pkg::servo_mode_e mode_ff; // operating mode
    dc_servo_pkg::corr_bank_t preset_ff; // preset corrections
    dc_servo_pkg::servo_mode_e seq_mode_ff; // sequencer mode entry
    logic [3:0] seq_ena_ff; // sequencer enable entry
    dc_servo_pkg::servo_state_e state_ff;
    dc_servo_pkg::servo_state_e nxt_state;
    logic meas_req_ff;
    logic nxt_req;
    logic [1:0] chan_ff;
    logic [1:0] nxt_chan;
    logic [3:0] have_ff; // slot holds a valid correction
    logic [3:0] nxt_have;
    logic [3:0] init_ff; // slot needs initial correction in current mode
    logic [3:0] nxt_init;
    logic [3:0] upd_ff; // slot due for periodic update
    logic [3:0] nxt_upd;
    dc_servo_pkg::corr_bank_t corr_ff;
    dc_servo_pkg::corr_bank_t nxt_corr;
    logic [dc_servo_pkg::TIMER_W-1:0] timer_ff;
    logic [3:0] apply_ff;
    logic [6:0] idx; // word index of the bus address
    logic bus_take; // request answered at this edge
    logic wr_take; // write lands at this edge
    logic mode_chg; // mode field replaced this edge
    logic [3:0] need_init;
    logic [3:0] need_upd;
    logic [1:0] sel_init;
    logic [1:0] sel_upd;
    logic preset_mode;
    logic tick; // periodic interval elapsed

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // highest pending slot first, so headphones are served before lines
    function automatic logic [1:0] pick(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (v[i])
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // read decode; unmapped words and reserved bits read as zero
    function automatic logic [7:0] reg_read(input logic [6:0] i);
        logic [7:0] r;
        r = 8'h00;
        unique case (i)
            dc_servo_pkg::ENABLE_CTRL_IDX: r = {3'h0, master_ff, out_en_ff};
            dc_servo_pkg::MODE_CTRL_IDX: r = {6'h00, mode_ff};
            dc_servo_pkg::PRESET_HPL_IDX: r = preset_ff[dc_servo_pkg::CH_HPL];
            dc_servo_pkg::PRESET_HPR_IDX: r = preset_ff[dc_servo_pkg::CH_HPR];
            dc_servo_pkg::PRESET_LNL_IDX: r = preset_ff[dc_servo_pkg::CH_LNL];
            dc_servo_pkg::PRESET_LNR_IDX: r = preset_ff[dc_servo_pkg::CH_LNR];
            dc_servo_pkg::READBACK_HPL_IDX: r = corr_ff[dc_servo_pkg::CH_HPL];
            dc_servo_pkg::READBACK_HPR_IDX: r = corr_ff[dc_servo_pkg::CH_HPR];
            dc_servo_pkg::READBACK_LNL_IDX: r = corr_ff[dc_servo_pkg::CH_LNL];
            dc_servo_pkg::READBACK_LNR_IDX: r = corr_ff[dc_servo_pkg::CH_LNR];
            dc_servo_pkg::SEQ_MODE_IDX: r = {6'h00, seq_mode_ff};
            dc_servo_pkg::SEQ_ENABLE_IDX: r = {4'h0, seq_ena_ff};
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // avalon-mm slave
    // ------------------------------------------------------------
    assign idx = avs_address[8:2];
    assign bus_take = (avs_read | avs_write) & ~wait_ff;
    assign wr_take = bus_take & avs_write & (avs_address[1:0] == 2'h0) & avs_byteenable[0];
    assign mode_chg = seq_run | (wr_take & (idx == dc_servo_pkg::MODE_CTRL_IDX));

    // every request is answered on its second cycle
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_ff <= 1'h1;
        end
        else
        begin
            wait_ff <= ~((avs_read | avs_write) & wait_ff);
        end
    end

    // read data captured while waitrequest is still high
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_ff <= 32'h00000000;
        end
        else if (avs_read & wait_ff)
        begin
            // misaligned byte addresses are unmapped
            rdata_ff <= (avs_address[1:0] == 2'h0) ? {24'h000000, reg_read(idx)} : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // control registers; a sequencer run beats a same-cycle bus write
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            master_ff <= dc_servo_pkg::MASTER_RST;
            out_en_ff <= dc_servo_pkg::OUT_EN_RST;
            mode_ff <= dc_servo_pkg::MODE_RST;
        end
        else if (seq_run)
        begin
            // sequence loads its entries into the live fields
            mode_ff <= seq_mode_ff;
            out_en_ff <= seq_ena_ff;
        end
        else if (wr_take && idx == dc_servo_pkg::ENABLE_CTRL_IDX)
        begin
            master_ff <= avs_writedata[dc_servo_pkg::MASTER_BIT];
            out_en_ff <= avs_writedata[3:0];
        end
        else if (wr_take && idx == dc_servo_pkg::MODE_CTRL_IDX)
        begin
            mode_ff <= dc_servo_pkg::servo_mode_e'(avs_writedata[1:0]);
        end
    end

    // preset values and sequencer entries
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            preset_ff <= {4{dc_servo_pkg::PRESET_RST}};
            seq_mode_ff <= dc_servo_pkg::SEQ_MODE_RST;
            seq_ena_ff <= dc_servo_pkg::SEQ_ENABLE_RST;
        end
        else if (wr_take)
        begin
            unique case (idx)
                dc_servo_pkg::PRESET_HPL_IDX: preset_ff[3] <= avs_writedata[7:0];
                dc_servo_pkg::PRESET_HPR_IDX: preset_ff[2] <= avs_writedata[7:0];
                dc_servo_pkg::PRESET_LNL_IDX: preset_ff[1] <= avs_writedata[7:0];
                dc_servo_pkg::PRESET_LNR_IDX: preset_ff[0] <= avs_writedata[7:0];
                dc_servo_pkg::SEQ_MODE_IDX:
                    seq_mode_ff <= dc_servo_pkg::servo_mode_e'(avs_writedata[1:0]);
                dc_servo_pkg::SEQ_ENABLE_IDX: seq_ena_ff <= avs_writedata[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // update interval timer
    // ------------------------------------------------------------
    assign tick = master_ff & mode_ff[0] & (|out_en_ff) & (timer_ff == TICK_LAST);

    // restarts on any mode change, so a new mode gets a full interval
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            timer_ff <= '0;
        end
        else if (!master_ff || !mode_ff[0] || out_en_ff == 4'h0 || mode_chg || tick)
        begin
            timer_ff <= '0;
        end
        else
        begin
            timer_ff <= timer_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // correction engine
    // ------------------------------------------------------------
    assign preset_mode = ~mode_ff[1];
    // a cleared enable keeps have_ff, so re-enabling needs no new work
    assign need_init = out_en_ff & (~have_ff | init_ff);
    assign need_upd = out_en_ff & upd_ff;
    assign sel_init = pick(need_init);
    assign sel_upd = pick(need_upd);

    // next-state logic; flags are cleared first so a set wins
    always_comb
    begin
        nxt_state = state_ff;
        nxt_req = meas_req_ff;
        nxt_chan = chan_ff;
        nxt_have = have_ff;
        nxt_init = init_ff;
        nxt_upd = upd_ff;
        nxt_corr = corr_ff;
        unique case (state_ff)
            dc_servo_pkg::ST_IDLE:
            begin
                if (|need_init && preset_mode)
                begin
                    // preset modes load the stored value, no measurement
                    nxt_corr[sel_init] = preset_ff[sel_init];
                    nxt_have[sel_init] = 1'b1;
                    nxt_init[sel_init] = 1'b0;
                end
                else if (|need_init)
                begin
                    nxt_req = 1'b1;
                    nxt_chan = sel_init;
                    nxt_state = dc_servo_pkg::ST_MEAS;
                end
                else if (|need_upd)
                begin
                    // periodic update measures in either periodic mode
                    nxt_req = 1'b1;
                    nxt_chan = sel_upd;
                    nxt_state = dc_servo_pkg::ST_MEAS;
                end
            end
            dc_servo_pkg::ST_MEAS:
            begin
                if (meas_ans.valid)
                begin
                    nxt_req = 1'b0;
                    nxt_corr[chan_ff] = meas_ans.value;
                    nxt_have[chan_ff] = 1'b1;
                    nxt_init[chan_ff] = 1'b0;
                    nxt_upd[chan_ff] = 1'b0;
                    nxt_state = dc_servo_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_req = 1'b0;
                nxt_state = dc_servo_pkg::ST_IDLE;
            end
        endcase
        // a mode change redoes the initial step, stale updates dropped
        if (mode_chg)
        begin
            nxt_init = 4'hF;
            nxt_upd = 4'h0;
        end
        if (tick)
        begin
            nxt_upd = 4'hF;
        end
    end

    // engine registers; global enable low holds everything in reset
    // the enable clear is a separate synchronous branch, so the async reset stays pure
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= dc_servo_pkg::ST_IDLE;
            meas_req_ff <= 1'b0;
            chan_ff <= 2'h0;
            have_ff <= 4'h0;
            init_ff <= 4'h0;
            upd_ff <= 4'h0;
            corr_ff <= '0;
        end
        else if (!master_ff)
        begin
            state_ff <= dc_servo_pkg::ST_IDLE;
            meas_req_ff <= 1'b0;
            chan_ff <= 2'h0;
            have_ff <= 4'h0;
            init_ff <= 4'h0;
            upd_ff <= 4'h0;
            corr_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            meas_req_ff <= nxt_req;
            chan_ff <= nxt_chan;
            have_ff <= nxt_have;
            init_ff <= nxt_init;
            upd_ff <= nxt_upd;
            corr_ff <= nxt_corr;
        end
    end

    // drive enable per output: retained value reapplied as soon as enabled
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            apply_ff <= 4'h0;
        end
        else
        begin
            apply_ff <= master_ff ? (out_en_ff & have_ff) : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_waitrequest = wait_ff;
    assign avs_readdata = rdata_ff;
    assign meas_req = '{req: meas_req_ff, chan: chan_ff};
    assign corr_value = corr_ff;
    assign corr_apply = apply_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence preset_load;
        state_ff == dc_servo_pkg::ST_IDLE && preset_mode && need_init != 4'h0 && master_ff;
    endsequence

    a_master_off_drop: assert property (!master_ff |=> corr_apply == 4'h0 && corr_ff == '0)
        else $error("servo not cleared while global enable is low");
    a_apply_gated: assert property (
        corr_apply != 4'h0 |-> (corr_apply & ~$past(out_en_ff)) == 4'h0)
        else $error("correction applied to a disabled output");
    a_mode_write: assert property (
        wr_take && idx == dc_servo_pkg::MODE_CTRL_IDX && !seq_run
        |=> mode_ff == $past(avs_writedata[1:0]))
        else $error("mode write not taken");
    a_once_no_meas: assert property (
        state_ff == dc_servo_pkg::ST_IDLE && !mode_ff[0] && need_init == 4'h0
        |=> !meas_req.req)
        else $error("measurement started in a once mode with nothing pending");
    a_tick_refresh: assert property (tick |=> upd_ff == 4'hF && timer_ff == '0)
        else $error("interval end did not schedule updates");
    a_preset_loads: assert property (
        preset_load
        |=> corr_ff[$past(sel_init)] == $past(preset_ff[sel_init]) && !meas_req.req)
        else $error("preset not loaded as correction");
    a_retain_off: assert property (
        master_ff && out_en_ff == 4'h0 && state_ff == dc_servo_pkg::ST_IDLE
        |=> $stable(corr_ff) && $stable(have_ff))
        else $error("correction lost while outputs disabled");
    a_readback_value: assert property (
        bus_take && avs_read && avs_address == {dc_servo_pkg::READBACK_HPL_IDX, 2'h0}
        |-> avs_readdata[7:0] == $past(corr_ff[3]))
        else $error("readback differs from correction");
    a_seq_loads_mode: assert property (
        seq_run |=> mode_ff == $past(seq_mode_ff) && out_en_ff == $past(seq_ena_ff))
        else $error("sequencer entries not applied");
    a_mode_keeps_corr: assert property (
        mode_chg && state_ff == dc_servo_pkg::ST_MEAS && !meas_ans.valid && master_ff
        |=> $stable(corr_ff) && init_ff == 4'hF)
        else $error("mode change corrupted correction");

endmodule
`default_nettype wire

// ==== design/dc_servo_pkg.sv ====
// package: register map, field layout, modes and timing of the offset servo
//
// Behaviour
// - global enable off resets servo, drops correction
// - four bits enable correction per output
// - two-bit field selects one of four modes
// - measure-once measures each output once, then holds
// - measure-periodic repeats measurement about every ten minutes
// - preset modes take initial correction from preset registers
// - preset-once stops; preset-periodic then measures periodically
// - cleared output keeps correction, reapplied when set
// - current correction readable in read-only readback registers
// - correction values are eight-bit two's complement
// - start-up sequence selects measure-once by default
`default_nettype none
package dc_servo_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam logic [6:0] ENABLE_CTRL_IDX = 7'h43;
    localparam logic [6:0] MODE_CTRL_IDX = 7'h45;
    localparam logic [6:0] PRESET_HPL_IDX = 7'h47;
    localparam logic [6:0] PRESET_HPR_IDX = 7'h48;
    localparam logic [6:0] PRESET_LNL_IDX = 7'h49;
    localparam logic [6:0] PRESET_LNR_IDX = 7'h4A;
    localparam logic [6:0] READBACK_HPL_IDX = 7'h51;
    localparam logic [6:0] READBACK_HPR_IDX = 7'h52;
    localparam logic [6:0] READBACK_LNL_IDX = 7'h53;
    localparam logic [6:0] READBACK_LNR_IDX = 7'h54;
    localparam logic [6:0] SEQ_MODE_IDX = 7'h60;
    localparam logic [6:0] SEQ_ENABLE_IDX = 7'h61;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int MASTER_BIT = 4;
    localparam logic MASTER_RST = 1'h1;
    localparam logic [3:0] OUT_EN_RST = 4'h0;
    localparam logic [3:0] SEQ_ENABLE_RST = 4'hF;
    localparam logic [7:0] PRESET_RST = 8'h00;
    // correction lsb in microvolts, two's complement byte
    localparam int CORR_LSB_UV = 250;
    localparam int CORR_W = 8;

    // output slots, numbered as their enable bit
    localparam logic [1:0] CH_HPL = 2'h3;
    localparam logic [1:0] CH_HPR = 2'h2;
    localparam logic [1:0] CH_LNL = 2'h1;
    localparam logic [1:0] CH_LNR = 2'h0;

    // operating modes; bit 1 picks measurement, bit 0 periodic update
    typedef enum logic [1:0] {
        PRESET_ONCE = 2'h0,
        PRESET_PERIODIC = 2'h1,
        MEASURE_ONCE = 2'h2,
        MEASURE_PERIODIC = 2'h3
    } servo_mode_e;
    localparam servo_mode_e MODE_RST = PRESET_ONCE;
    localparam servo_mode_e SEQ_MODE_RST = MEASURE_ONCE;

    // engine states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_MEAS = 2'b10
    } servo_state_e;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 250000000;
    localparam longint UPDATE_PERIOD_S = 600;
    localparam longint UPDATE_CYCLES = UPDATE_PERIOD_S * CLK_HZ;
    localparam int TIMER_W = 40;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef logic [3:0][CORR_W-1:0] corr_bank_t;
    typedef struct packed {
        logic req;
        logic [1:0] chan;
    } meas_req_s;
    typedef struct packed {
        logic valid;
        logic [CORR_W-1:0] value;
    } meas_ans_s;

endpackage
`default_nettype wire

// ==== verif/dc_offset_servo_control_tb.sv ====
// testbench: register map, correction modes and start-up sequence of the offset servo
`timescale 1ns/1ns
`default_nettype none
module dc_offset_servo_control_tb;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic core_clk;
    logic sys_rst;
    logic [dc_servo_pkg::ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic seq_run;
    dc_servo_pkg::meas_req_s meas_req;
    dc_servo_pkg::meas_ans_s meas_ans = '0; // driven only by the stand-in below
    dc_servo_pkg::corr_bank_t corr_value;
    logic [3:0] corr_apply;
    int fail_count = 0;
    int cmp_count = 0;
    int meas_cnt = 0; // answers given by the front-end stand-in
    int wait_cnt = 0; // cycles the current request has waited
    int ans_delay = 1; // answer delay, raised later for slow answers
    int meas_base = 0; // answers counted before the start-up run
    logic [7:0] ans_val [4]; // index 0 is headphone left
    logic [7:0] pre [4] = '{8'h7F, 8'h80, 8'h01, 8'hFF}; // two's complement extremes, then +1 and -1
    logic [1:0] chan_log [$];
    logic [31:0] rd;

    // short period so several periodic updates fit in the run
    dc_offset_servo_control #(.UPDATE_PERIOD_CYCLES(200)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .seq_run(seq_run), .meas_req(meas_req),
        .meas_ans(meas_ans), .corr_value(corr_value), .corr_apply(corr_apply));

    // 250 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // measurement front end stand-in
    // ------------------------------------------------------------
    // answers each request after ans_delay cycles; value scrambles while idle
    always @(posedge core_clk)
    begin
        if (meas_req.req === 1'b1 && meas_ans.valid !== 1'b1 && wait_cnt >= ans_delay)
        begin
            meas_ans.valid <= 1'b1;
            meas_ans.value <= ans_val[3 - meas_req.chan];
            chan_log.push_back(meas_req.chan);
            meas_cnt <= meas_cnt + 1;
            wait_cnt <= 0;
        end
        else
        begin
            meas_ans.valid <= 1'b0;
            meas_ans.value <= ~meas_ans.value;
            wait_cnt <= (meas_req.req === 1'b1) ? wait_cnt + 1 : 0;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                fail_count++;
                $display("MISMATCH %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // one avalon transfer; request held until waitrequest is sampled low at a rising edge
    // no cycle count is assumed here: only the watchdog ends a hung wait
    task automatic bus_xfer(input logic wr, input logic [6:0] idx, input logic [7:0] d);
        begin
            @(posedge core_clk);
            avs_address <= {idx, 2'b00};
            avs_writedata <= {24'h0, d};
            avs_write <= wr;
            avs_read <= ~wr;
            @(posedge core_clk);
            while (avs_waitrequest !== 1'b0)
                @(posedge core_clk);
            // same edge: write lands, read data taken, then release
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        bus_xfer(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [6:0] idx, input logic [31:0] exp);
        begin
            bus_xfer(1'b0, idx, 8'h00);
            chk($sformatf("register %h", idx), exp, rd);
        end
    endtask

    // bounded wait for a correction bank and apply mask, then compare
    task automatic wait_corr(input logic [31:0] v, input logic [3:0] a);
        int n;
        begin
            n = 0;
            while ((corr_value !== v || corr_apply !== a) && n < 1000)
            begin
                @(negedge core_clk);
                n++;
            end
            chk("corr_value", v, corr_value);
            chk("corr_apply", {28'h0, a}, {28'h0, corr_apply});
        end
    endtask

    task automatic wait_meas(input int target);
        int n;
        begin
            n = 0;
            while (meas_cnt < target && n < 2000)
            begin
                @(negedge core_clk);
                n++;
            end
            chk("measurement count", 32'(target), 32'(meas_cnt));
        end
    endtask

    task automatic conclude;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // hang guard, well beyond the few thousand cycles the tests need
    initial
    begin
        #200000;
        fail_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        seq_run = 1'b0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values and refused accesses
        rd_chk(dc_servo_pkg::ENABLE_CTRL_IDX, 32'h10);
        rd_chk(dc_servo_pkg::MODE_CTRL_IDX, 32'h00);
        for (int i = 0; i < 4; i++)
        begin
            rd_chk(dc_servo_pkg::PRESET_HPL_IDX + 7'(i), 32'h00);
            rd_chk(dc_servo_pkg::READBACK_HPL_IDX + 7'(i), 32'h00);
        end
        rd_chk(7'h4F, 32'h00);
        wr(dc_servo_pkg::READBACK_HPL_IDX, 8'h55);
        rd_chk(dc_servo_pkg::READBACK_HPL_IDX, 32'h00);
        // preset-once: presets first, then enable all outputs
        for (int i = 0; i < 4; i++)
            wr(dc_servo_pkg::PRESET_HPL_IDX + 7'(i), pre[i]);
        wr(dc_servo_pkg::ENABLE_CTRL_IDX, 8'h1F);
        wait_corr(32'h7F8001FF, 4'hF);
        for (int i = 0; i < 4; i++)
            rd_chk(dc_servo_pkg::READBACK_HPL_IDX + 7'(i), {24'h0, pre[i]});
        // one output off and on again keeps its value without measuring
        wr(dc_servo_pkg::ENABLE_CTRL_IDX, 8'h17);
        wait_corr(32'h7F8001FF, 4'h7);
        wr(dc_servo_pkg::ENABLE_CTRL_IDX, 8'h1F);
        wait_corr(32'h7F8001FF, 4'hF);
        chk("no measurement", 32'h0, 32'(meas_cnt));
        // measure-once: one pass, highest slot first, then silence
        ans_val = '{8'h10, 8'hF0, 8'h05, 8'hFB};
        wr(dc_servo_pkg::MODE_CTRL_IDX, 8'h02);
        wait_meas(4);
        wait_corr(32'h10F005FB, 4'hF);
        for (int i = 0; i < 4; i++)
            chk("slot order", 32'(3 - i), {30'h0, chan_log[i]});
        repeat (400) @(negedge core_clk);
        chk("single pass", 32'h4, 32'(meas_cnt));
        rd_chk(dc_servo_pkg::READBACK_LNR_IDX, 32'hFB);
        // measure-periodic with slow answers: initial pass, then repeats
        ans_val = '{8'h20, 8'hE0, 8'h0A, 8'hF6};
        ans_delay = 6;
        wr(dc_servo_pkg::MODE_CTRL_IDX, 8'h03);
        // rewrite while the first slow answer is pending: no extra pass, value kept
        wr(dc_servo_pkg::MODE_CTRL_IDX, 8'h03);
        wait_meas(8);
        wait_corr(32'h20E00AF6, 4'hF);
        wait_meas(12);
        // preset-periodic: presets reload, then periodic measurement
        ans_val = '{8'h10, 8'hF0, 8'h05, 8'hFB};
        wr(dc_servo_pkg::MODE_CTRL_IDX, 8'h01);
        wait_corr(32'h7F8001FF, 4'hF);
        wait_corr(32'h10F005FB, 4'hF);
        // global enable off clears corrections and apply mask and stops the engine
        wr(dc_servo_pkg::ENABLE_CTRL_IDX, 8'h0F);
        wait_corr(32'h0, 4'h0);
        repeat (20) @(negedge core_clk);
        rd = 32'(meas_cnt);
        repeat (400) @(negedge core_clk);
        chk("engine held", rd, 32'(meas_cnt));
        // start-up sequence with edited enable entry, default mode entry
        wr(dc_servo_pkg::ENABLE_CTRL_IDX, 8'h10);
        wr(dc_servo_pkg::SEQ_ENABLE_IDX, 8'h0C);
        rd_chk(dc_servo_pkg::SEQ_MODE_IDX, 32'h02);
        meas_base = meas_cnt;
        @(posedge core_clk);
        seq_run <= 1'b1;
        @(posedge core_clk);
        seq_run <= 1'b0;
        rd_chk(dc_servo_pkg::MODE_CTRL_IDX, 32'h02);
        rd_chk(dc_servo_pkg::ENABLE_CTRL_IDX, 32'h1C);
        wait_meas(meas_base + 2);
        wait_corr(32'h10F00000, 4'hC);
        conclude();
    end
endmodule
`default_nettype wire
